// *** src/sase_consts.vh ***
// Constants for the skip-and-subtract execution block
`ifndef SASE_CONSTS_VH
`define SASE_CONSTS_VH
`define SASE_OP_NONE 3'h0
`define SASE_OP_INCM 3'h1
`define SASE_OP_INCW 3'h2
`define SASE_OP_BITS 3'h3
`define SASE_OP_SUBW 3'h4
`define SASE_OP_MINUS_TO_MEMORY 3'h5
`define SASE_OP_SUBI 3'h6
`define SASE_ONE 8'h01
`define SASE_ZERO 8'h00
`define SASE_WORK_RST 8'h00
`define SASE_MSB 7
`define SASE_NIB 4
`endif

// *** src/sase_exec.v ***
// Execution unit for increment-skip, bit-skip and subtract instructions
`include "sase_consts.vh"
module sase_exec #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire arst_n,
  input wire issueValid,
  input wire [2:0] opCode,
  input wire [WIDTH-1:0] memData,
  input wire [2:0] bitSel,
  input wire [WIDTH-1:0] immData,
  output reg [WIDTH-1:0] workingRegister_q,
  output reg memWrite_q,
  output reg [WIDTH-1:0] memWriteData_q,
  output reg skipTaken_q,
  output reg dummyCycle_q,
  output reg busy_q,
  output reg borrowBit_q,
  output reg zeroBit_q,
  output reg signedWrapBit_q,
  output reg nibbleBorrowBit_q
);

  // Timing in short: an instruction is taken at an edge and its results show
  // in the next cycle. A taken skip raises the skip, dummy and busy pulses in
  // that same next cycle, so whatever the fetch side presents then is the
  // skipped instruction and is dropped. The skipping instruction therefore
  // spans two machine cycles. The fetch side must not hold back the skipped
  // instruction: it is the one that gets thrown away.

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire accepted;
  wire isIncMem;
  wire isIncWork;
  wire isBitSkip;
  wire isSubWork;
  wire isSubMem;
  wire isSubImm;
  wire isSub;

  // The slot after a taken skip holds the skipped instruction, so it is refused
  assign accepted = issueValid & ~dummyCycle_q;
  // One strobe per class, each already gated by the accept term
  assign isIncMem = accepted & (opCode == `SASE_OP_INCM);
  assign isIncWork = accepted & (opCode == `SASE_OP_INCW);
  assign isBitSkip = accepted & (opCode == `SASE_OP_BITS);
  assign isSubWork = accepted & (opCode == `SASE_OP_SUBW);
  assign isSubMem = accepted & (opCode == `SASE_OP_MINUS_TO_MEMORY);
  assign isSubImm = accepted & (opCode == `SASE_OP_SUBI);
  // Unused codes decode to nothing, so they act as a plain idle cycle
  assign isSub = isSubWork | isSubMem | isSubImm;

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  wire [WIDTH-1:0] incSum;
  wire incZero;
  wire [WIDTH-1:0] subB;
  wire [WIDTH:0] subFull;
  wire [WIDTH-1:0] subRes;
  wire subZero;
  wire subWrap;
  wire [`SASE_NIB:0] nibFull;
  wire bitHit;

  // Increment wraps, so 0xff rolls to zero and triggers the skip
  assign incSum = memData + `SASE_ONE;
  assign incZero = (incSum == `SASE_ZERO);

  // Immediate subtract takes its operand from the instruction word
  assign subB = (opCode == `SASE_OP_SUBI) ? immData : memData;
  // One extra bit catches the borrow out of the top
  assign subFull = {1'b0, workingRegister_q} - {1'b0, subB};
  assign subRes = subFull[WIDTH-1:0];
  assign subZero = (subRes == `SASE_ZERO);
  // Overflow when operand signs differ and the result sign leaves the minuend's
  assign subWrap = (workingRegister_q[`SASE_MSB] ^ subB[`SASE_MSB]) &
    (subRes[`SASE_MSB] ^ workingRegister_q[`SASE_MSB]);
  // Low nibble worked separately; its top bit is the nibble borrow
  assign nibFull = {1'b0, workingRegister_q[`SASE_NIB-1:0]} - {1'b0, subB[`SASE_NIB-1:0]};

  // Bit test reads one bit; the memory byte itself is never written here
  assign bitHit = memData[bitSel];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  reg skipCond;
  reg [WIDTH-1:0] workingRegister_d;
  reg memWrite_d;
  reg [WIDTH-1:0] memWriteData_d;
  reg skipTaken_d;
  reg dummyCycle_d;
  reg busy_d;
  reg borrowBit_d;
  reg zeroBit_d;
  reg signedWrapBit_d;
  reg nibbleBorrowBit_d;

  // Skip condition: only the three skip classes can raise it
  always @* begin
    skipCond = 1'b0;
    if (isIncMem) begin
      skipCond = incZero;
    end
    if (isIncWork) begin
      skipCond = incZero;
    end
    if (isBitSkip) begin
      skipCond = bitHit;
    end
  end

  // A taken skip marks the very next slot as dummy, so the following
  // instruction is dropped and the skipping one spans two cycles
  always @* begin
    skipTaken_d = skipCond;
    dummyCycle_d = skipCond;
    busy_d = skipCond;
  end

  // Working register: increment-to-register and the two register subtracts
  always @* begin
    workingRegister_d = workingRegister_q;
    if (isIncWork) begin
      workingRegister_d = incSum;
    end
    if (isSubWork) begin
      workingRegister_d = subRes;
    end
    if (isSubImm) begin
      workingRegister_d = subRes;
    end
  end

  // Memory write port: a one-cycle strobe, data held until the next write
  always @* begin
    memWrite_d = 1'b0;
    memWriteData_d = memWriteData_q;
    if (isIncMem) begin
      memWrite_d = 1'b1;
      memWriteData_d = incSum;
    end
    if (isSubMem) begin
      memWrite_d = 1'b1;
      memWriteData_d = subRes;
    end
  end

  // Flags move only on a subtraction; skips and idle slots hold them
  always @* begin
    borrowBit_d = borrowBit_q;
    zeroBit_d = zeroBit_q;
    signedWrapBit_d = signedWrapBit_q;
    nibbleBorrowBit_d = nibbleBorrowBit_q;
    if (isSub) begin
      borrowBit_d = ~subFull[WIDTH];
      zeroBit_d = subZero;
      signedWrapBit_d = subWrap;
      nibbleBorrowBit_d = ~nibFull[`SASE_NIB];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Skip pulses: all three last exactly one cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skipTaken_q <= 1'b0;
      dummyCycle_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      skipTaken_q <= skipTaken_d;
      dummyCycle_q <= dummyCycle_d;
      busy_q <= busy_d;
    end
  end

  // Working register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      workingRegister_q <= `SASE_WORK_RST;
    end else begin
      workingRegister_q <= workingRegister_d;
    end
  end

  // Memory write strobe and data
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memWrite_q <= 1'b0;
      memWriteData_q <= `SASE_ZERO;
    end else begin
      memWrite_q <= memWrite_d;
      memWriteData_q <= memWriteData_d;
    end
  end

  // Status flags
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      borrowBit_q <= 1'b0;
      zeroBit_q <= 1'b0;
      signedWrapBit_q <= 1'b0;
      nibbleBorrowBit_q <= 1'b0;
    end else begin
      borrowBit_q <= borrowBit_d;
      zeroBit_q <= zeroBit_d;
      signedWrapBit_q <= signedWrapBit_d;
      nibbleBorrowBit_q <= nibbleBorrowBit_d;
    end
  end

endmodule

// *** verification/sase_exec_properties.sv ***
// Port checks for the skip-and-subtract unit
module sase_exec_properties (
  input wire clk, arst_n, issueValid, memWrite_q, skipTaken_q, dummyCycle_q, busy_q, borrowBit_q,
  input wire [2:0] opCode, bitSel,
  input wire [7:0] memData, workingRegister_q, memWriteData_q, immData
);
  // Accepted opcode, one-hot, and the results it should produce
  wire [7:0] op = {8{issueValid & ~dummyCycle_q}} & (8'h01 << opCode);
  wire [7:0] inc = memData + 8'h01;
  wire [7:0] dif = workingRegister_q - memData;
  wire [7:0] difi = workingRegister_q - immData;
  wire hit = memData[bitSel];
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_incm_wr: assert property (op[1] |=> memWrite_q && memWriteData_q == $past(inc)) else $error("incm");
  a_skip_dummy: assert property (skipTaken_q |-> dummyCycle_q) else $error("dummy");
  a_dummy_drop: assert property (dummyCycle_q |=> !memWrite_q && !skipTaken_q) else $error("drop");
  a_dummy_once: assert property (dummyCycle_q |=> !dummyCycle_q) else $error("once");
  a_subi_reg: assert property (op[6] |=> workingRegister_q == $past(difi)) else $error("subi");
  a_busy_pair: assert property (skipTaken_q |-> busy_q) else $error("busy");
  a_incw_reg: assert property (op[2] |=> workingRegister_q == $past(inc)) else $error("incw");
  a_bit_skip: assert property (op[3] |=> skipTaken_q == $past(hit)) else $error("bit");
  a_subw_reg: assert property (op[4] |=> workingRegister_q == $past(dif)) else $error("subw");
  a_minus_to_memory_mem: assert property (op[5] |=> memWriteData_q == $past(dif)) else $error("minus_to_memory");
  a_flags_kept: assert property (op[3] |=> $stable(borrowBit_q)) else $error("flag");
endmodule
bind sase_exec sase_exec_properties chk_u (.*);

// *** verification/skip_and_subtract_exec_tb.sv ***
// Random bench with a reference model for the skip-and-subtract unit
module skip_and_subtract_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, iv = 0, s = 0, d = 0, g, c = 0, z = 0, v = 0, n = 0, m = 0;
  logic [2:0] op = 0, bs = 0;
  logic [7:0] md = 0, im = 0, w = 0, k = 0, r, o;
  logic [31:0] x = 20;
  wire [23:0] q;
  int fails = 0, total_checks = 0;
  sase_exec dut_u (.clk, .arst_n, .issueValid(iv), .opCode(op), .memData(md), .bitSel(bs), .immData(im),
    .workingRegister_q(q[23:16]), .memWriteData_q(q[15:8]), .memWrite_q(q[7]), .skipTaken_q(q[6]),
    .dummyCycle_q(q[5]), .busy_q(q[4]), .borrowBit_q(q[3]), .zeroBit_q(q[2]), .signedWrapBit_q(q[1]),
    .nibbleBorrowBit_q(q[0]));
  // Clock
  initial forever #2.5 clk = ~clk;
  task automatic check(input logic [23:0] a, e);
    total_checks++;
    if (a !== e) begin
      fails++;
      $display("CHECK FAILED %0t %h %h", $time, a, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Outputs are read before this edge moves them, so the model lags one step on purpose
  always @(posedge clk) begin
    if (arst_n) begin
      check(q, {w, k, m, s, d, s, c, z, v, n});
      g = iv & ~d;
      {d, s, m} = 3'b000;
      if (g) case (op)
        1, 2: begin
          r = md + 8'h01;
          s = r == 8'h00;
          if (op == 1) {m, k} = {1'b1, r};
          else w = r;
        end
        3: s = md[bs];
        4, 5, 6: begin
          o = op == 6 ? im : md;
          r = w - o;
          {c, z, n, v} = {w >= o, r == 8'h00, w[3:0] >= o[3:0], (w[7] ^ o[7]) & (r[7] ^ w[7])};
          if (op == 5) {m, k} = {1'b1, r};
          else w = r;
        end
      endcase
      d = s;
    end
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    {iv, op, bs, im} <= {|x[1:0], x[15:2]};
    md <= x[16] ? 8'hff : x[31:24];
  end
  // Reset, run, then the verdict
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1;
    repeat (3000) @(posedge clk);
    report_and_stop;
  end
  // Watchdog
  initial begin
    #20000;
    fails++;
    report_and_stop;
  end
endmodule
